// >>> inc/tss_params.svh
// Register offsets, field positions, reset values for the trace sink block
`ifndef TSS_PARAMS_SVH
`define TSS_PARAMS_SVH
`define TSS_OFF_SYNC_RELOAD 12'h308
`define TSS_OFF_EVT_OUT 12'hee0
`define TSS_OFF_TRIG_FLUSH 12'hee8
`define TSS_OFF_DATA_SAMPLE 12'heec
`define TSS_OFF_TRACE_OUT 12'hef0
`define TSS_OFF_ID_SAMPLE 12'hef4
`define TSS_OFF_CTRL_SAMPLE 12'hef8
`define TSS_OFF_INTEG_MODE 12'hf00
`define TSS_RELOAD_RESET 5'h0a
`define TSS_RELOAD_MAX 5'h1b
`define TSS_RELOAD_MIN 5'h07
`define TSS_BIT_FLUSH 2
`define TSS_BIT_FULL 1
`define TSS_BIT_CAPT 0
`define TSS_BIT_SYNCREQ 2
`define TSS_BIT_AFVALID 1
`define TSS_BIT_ATREADY 0
`define TSS_BIT_FLUSH_IN 1
`define TSS_BIT_TRIG_IN 0
`define TSS_BYTES_LSB 8
`define TSS_RESP_OKAY 2'h0
`define TSS_RESP_SLVERR 2'h2
`endif

// >>> inc/tss_pkg.sv
// Types shared by the trace sink sync and integration block
package tss_pkg;
    typedef struct packed {
        logic [11:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [11:0] araddr;
        logic arvalid;
        logic rready;
    } tss_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } tss_axi_rsp_t;

    typedef enum logic [1:0] {
        TSS_WR_IDLE = 2'b01,
        TSS_WR_RESP = 2'b10
    } tss_wr_state_t;

    typedef enum logic [1:0] {
        TSS_RD_IDLE = 2'b01,
        TSS_RD_DATA = 2'b10
    } tss_rd_state_t;
endpackage

// >>> design/tss_trace_sink_regs.sv
// Sync counter and integration registers of a trace memory sink
`include "tss_params.svh"

module tss_trace_sink_regs #(
    parameter int DATA_WIDTH = 128,
    parameter int BYTES_WIDTH = 4
) (
    input wire logic ref_clk, // 10 MHz clock
    input wire logic sys_rst, // Synchronous reset, active high
    input wire tss_pkg::tss_axi_req_t axiReq, // AXI4-Lite request
    output tss_pkg::tss_axi_rsp_t axiRsp, // AXI4-Lite response
    input wire logic captureEnable, // Trace capture enabled
    input wire logic storeValid, // Bytes stored to trace memory
    input wire logic [BYTES_WIDTH:0] storeBytes, // Byte count stored
    input wire logic flushDoneFunc, // Functional flush complete
    input wire logic bufferFullFunc, // Functional buffer full
    input wire logic captureDoneFunc, // Functional capture complete
    input wire logic afvalidFunc, // Functional flush request
    input wire logic atreadyFunc, // Functional trace ready
    input wire logic flush_request_in, // Flush request input
    input wire logic trigger_pulse_in, // Trigger input
    input wire logic [DATA_WIDTH-1:0] atdata_s, // Trace data
    input wire logic [6:0] atid_s, // Trace source id
    input wire logic [BYTES_WIDTH-1:0] atbytes_s, // Trace byte count
    input wire logic atwakeup_s, // Wakeup
    input wire logic afready_s, // Flush acknowledge
    input wire logic atvalid_s, // Trace valid
    output logic flush_done_out, // Flush complete output
    output logic buffer_full_out, // Buffer full output
    output logic capture_done_out, // Capture complete output
    output logic syncreq_s, // Sync request, one-cycle pulse in functional mode, level from the trace out register in integration mode
    output logic afvalid_s, // Flush valid
    output logic atready_s, // Trace ready
    output logic integrationMode // Integration mode active
);
    import tss_pkg::*;

    localparam int SAMPLE_BITS = 1 + DATA_WIDTH / 8;

    typedef struct packed {
        tss_wr_state_t wrState;
        tss_rd_state_t rdState;
        logic [31:0] rdata;
        logic [1:0] bresp;
        logic [1:0] rresp;
        logic [4:0] reload;
        logic [4:0] activeReload;
        logic [27:0] count;
        logic imode;
        logic [2:0] evtOut;
        logic [2:0] traceOut;
        logic [1:0] trigFlush;
        logic flushInPrev;
        logic trigInPrev;
        logic syncPulse;
        logic flushDone;
        logic bufferFull;
        logic captureDone;
        logic afvalid;
        logic atready;
        logic syncReq;
    } tss_state_t;

    tss_state_t state_reg;
    tss_state_t state_next;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [4:0] fixReload(input logic [4:0] v);
        if (v == 5'h00) begin
            fixReload = 5'h00;
        end else if (v < `TSS_RELOAD_MIN || v > `TSS_RELOAD_MAX) begin
            fixReload = `TSS_RELOAD_MAX;
        end else begin
            fixReload = v;
        end
    endfunction

    function automatic logic [27:0] periodOf(input logic [4:0] v);
        periodOf = 28'h0000001 << v;
    endfunction

    function automatic logic [SAMPLE_BITS-1:0] sampleData(
        input logic [DATA_WIDTH-1:0] d);
        logic [SAMPLE_BITS-1:0] s;
        s = '0;
        s[0] = d[0];
        for (int i = 1; i < SAMPLE_BITS; i++) begin
            s[i] = d[8 * i - 1];
        end
        sampleData = s;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next state

    logic wrFire;
    logic rdFire;
    logic [11:0] rdAddr;
    logic [11:0] wrAddr;
    logic [31:0] rdValue;
    logic rdHit;
    logic wrHit;
    logic [27:0] dec;
    logic clrTrigFlush;
    logic [27:0] bytes28;

    always_comb begin
        state_next = state_reg;
        wrFire = 1'b0;
        rdFire = 1'b0;
        rdAddr = {axiReq.araddr[11:2], 2'b00};
        wrAddr = {axiReq.awaddr[11:2], 2'b00};
        rdValue = 32'h00000000;
        rdHit = 1'b1;
        wrHit = 1'b1;
        dec = 28'h0000000;
        clrTrigFlush = 1'b0;
        bytes28 = 28'(storeBytes);
        state_next.syncPulse = 1'b0;

        // Write channel: address and data taken together
        case (state_reg.wrState)
            TSS_WR_IDLE: begin
                if (axiReq.awvalid && axiReq.wvalid) begin
                    wrFire = 1'b1;
                    state_next.wrState = TSS_WR_RESP;
                end
            end
            TSS_WR_RESP: begin
                if (axiReq.bready) begin
                    state_next.wrState = TSS_WR_IDLE;
                end
            end
            default: state_next.wrState = TSS_WR_IDLE;
        endcase

        case (state_reg.rdState)
            TSS_RD_IDLE: begin
                if (axiReq.arvalid) begin
                    rdFire = 1'b1;
                    state_next.rdState = TSS_RD_DATA;
                end
            end
            TSS_RD_DATA: begin
                if (axiReq.rready) begin
                    state_next.rdState = TSS_RD_IDLE;
                end
            end
            default: state_next.rdState = TSS_RD_IDLE;
        endcase

        // Read decode; integration reads are zero in functional mode
        case (rdAddr)
            `TSS_OFF_SYNC_RELOAD: rdValue = {27'h0, state_reg.reload};
            `TSS_OFF_EVT_OUT: rdValue = 32'h00000000;
            `TSS_OFF_TRACE_OUT: rdValue = 32'h00000000;
            `TSS_OFF_TRIG_FLUSH: begin
                if (state_reg.imode) begin
                    rdValue = {30'h0, state_reg.trigFlush};
                end
                clrTrigFlush = rdFire;
            end
            `TSS_OFF_DATA_SAMPLE: begin
                if (state_reg.imode) begin
                    rdValue = 32'(sampleData(atdata_s));
                end
            end
            `TSS_OFF_ID_SAMPLE: begin
                if (state_reg.imode) begin
                    rdValue = {25'h0, atid_s};
                end
            end
            `TSS_OFF_CTRL_SAMPLE: begin
                if (state_reg.imode) begin
                    rdValue = 32'(atbytes_s) << `TSS_BYTES_LSB;
                    rdValue[2:0] = {atwakeup_s, afready_s, atvalid_s};
                end
            end
            `TSS_OFF_INTEG_MODE: rdValue = {31'h0, state_reg.imode};
            default: rdHit = 1'b0;
        endcase
        if (rdFire) begin
            state_next.rdata = rdValue;
            state_next.rresp = rdHit ? `TSS_RESP_OKAY : `TSS_RESP_SLVERR;
        end

        // Writes; integration writes need integration mode
        case (wrAddr)
            `TSS_OFF_SYNC_RELOAD: begin
                if (wrFire && axiReq.wstrb[0]) begin
                    state_next.reload = fixReload(axiReq.wdata[4:0]);
                end
            end
            `TSS_OFF_EVT_OUT: begin
                if (wrFire && axiReq.wstrb[0] && state_reg.imode) begin
                    state_next.evtOut = axiReq.wdata[2:0];
                end
            end
            `TSS_OFF_TRACE_OUT: begin
                if (wrFire && axiReq.wstrb[0] && state_reg.imode) begin
                    state_next.traceOut = axiReq.wdata[2:0];
                end
            end
            `TSS_OFF_INTEG_MODE: begin
                if (wrFire && axiReq.wstrb[0]) begin
                    state_next.imode = axiReq.wdata[0];
                end
            end
            `TSS_OFF_TRIG_FLUSH, `TSS_OFF_DATA_SAMPLE,
            `TSS_OFF_ID_SAMPLE, `TSS_OFF_CTRL_SAMPLE: wrHit = 1'b1;
            default: wrHit = 1'b0;
        endcase
        if (wrFire) begin
            state_next.bresp = wrHit ? `TSS_RESP_OKAY : `TSS_RESP_SLVERR;
        end

        // Input edge latches; a new edge wins over a read clear
        state_next.flushInPrev = flush_request_in;
        state_next.trigInPrev = trigger_pulse_in;
        if (!state_reg.imode) begin
            state_next.trigFlush = 2'b00;
        end else begin
            if (clrTrigFlush) begin
                state_next.trigFlush = 2'b00;
            end
            if (flush_request_in && !state_reg.flushInPrev) begin
                state_next.trigFlush[`TSS_BIT_FLUSH_IN] = 1'b1;
            end
            if (trigger_pulse_in && !state_reg.trigInPrev) begin
                state_next.trigFlush[`TSS_BIT_TRIG_IN] = 1'b1;
            end
        end
        if (!state_next.imode) begin
            state_next.evtOut = 3'b000;
            state_next.traceOut = 3'b000;
        end

        // Sync counter, counting down bytes stored
        if (state_reg.activeReload == 5'h00) begin
            state_next.activeReload = state_reg.reload;
            state_next.count = periodOf(state_reg.reload);
        end else if (captureEnable && storeValid) begin
            if (state_reg.count <= bytes28) begin
                state_next.syncPulse = 1'b1;
                state_next.activeReload = state_reg.reload;
                state_next.count = periodOf(state_reg.reload);
            end else begin
                dec = state_reg.count - bytes28;
                state_next.count = dec;
            end
        end

        // Output muxing between functional and integration drive
        if (state_next.imode) begin
            state_next.flushDone = state_next.evtOut[`TSS_BIT_FLUSH];
            state_next.bufferFull = state_next.evtOut[`TSS_BIT_FULL];
            state_next.captureDone = state_next.evtOut[`TSS_BIT_CAPT];
            state_next.afvalid = state_next.traceOut[`TSS_BIT_AFVALID];
            state_next.atready = state_next.traceOut[`TSS_BIT_ATREADY];
            state_next.syncReq = state_next.traceOut[`TSS_BIT_SYNCREQ];
        end else begin
            state_next.flushDone = flushDoneFunc;
            state_next.bufferFull = bufferFullFunc;
            state_next.captureDone = captureDoneFunc;
            state_next.afvalid = afvalidFunc;
            state_next.atready = atreadyFunc;
            state_next.syncReq = state_next.syncPulse;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_reg <= '0;
            state_reg.wrState <= TSS_WR_IDLE;
            state_reg.rdState <= TSS_RD_IDLE;
            state_reg.reload <= `TSS_RELOAD_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs from flip-flops, except awready and wready, which also decode wvalid and awvalid

    always_comb begin
        axiRsp.awready = state_reg.wrState == TSS_WR_IDLE && axiReq.wvalid;
        axiRsp.wready = state_reg.wrState == TSS_WR_IDLE && axiReq.awvalid;
        axiRsp.bvalid = state_reg.wrState == TSS_WR_RESP;
        axiRsp.bresp = state_reg.bresp;
        axiRsp.arready = state_reg.rdState == TSS_RD_IDLE;
        axiRsp.rvalid = state_reg.rdState == TSS_RD_DATA;
        axiRsp.rdata = state_reg.rdata;
        axiRsp.rresp = state_reg.rresp;
    end

    assign flush_done_out = state_reg.flushDone;
    assign buffer_full_out = state_reg.bufferFull;
    assign capture_done_out = state_reg.captureDone;
    assign syncreq_s = state_reg.syncReq;
    assign afvalid_s = state_reg.afvalid;
    assign atready_s = state_reg.atready;
    assign integrationMode = state_reg.imode;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    AST_RELOAD_LEGAL: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_reg.reload == 5'h00 || (state_reg.reload >= 5'h07 &&
        state_reg.reload <= 5'h1b))
        else $error("reload field holds reserved value");
    AST_NO_SYNC_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !state_reg.imode && state_reg.activeReload == 5'h00
        |=> !state_reg.syncPulse)
        else $error("sync issued while disabled");
    AST_SYNC_RELOADS: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_next.syncPulse |=>
        state_reg.count == periodOf(state_reg.activeReload))
        else $error("counter not reloaded after sync");
    AST_COUNT_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !captureEnable && state_reg.activeReload != 5'h00
        |=> $stable(state_reg.count))
        else $error("counter moved with capture off");
    AST_RAZ_FUNC: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rdFire && !state_reg.imode && rdAddr >= 12'hee0 && rdAddr <= 12'hef8
        |=> axiRsp.rdata == 32'h00000000)
        else $error("integration read nonzero in functional mode");
    AST_WO_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rdFire && (rdAddr == 12'hee0 || rdAddr == 12'hef0)
        |=> axiRsp.rdata == 32'h00000000)
        else $error("write-only register read nonzero");
    AST_LATCH_CLEAR: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !state_reg.imode |=> state_reg.trigFlush == 2'b00)
        else $error("trigger flush status kept outside integration");
    AST_FLUSH_EDGE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_reg.imode && state_next.imode && flush_request_in &&
        !state_reg.flushInPrev |=> state_reg.trigFlush[1])
        else $error("flush edge not latched");
    AST_EVT_DRIVE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_reg.imode |-> flush_done_out == state_reg.evtOut[2] &&
        capture_done_out == state_reg.evtOut[0])
        else $error("event outputs not driven from register");
    AST_MODE_READ: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rdFire && rdAddr == 12'hf00 |=>
        axiRsp.rdata == {31'h0, $past(state_reg.imode)})
        else $error("mode control readback wrong");
endmodule

// >>> dv/tss_trace_src.sv
// Trace source model standing on the trace-bus side of the sink
module tss_trace_src (
    input wire logic ref_clk, // Clock
    input wire logic sys_rst, // Synchronous reset
    input wire logic syncreq_s, // Sync request from sink
    input wire logic afvalid_s, // Flush request from sink
    input wire logic slow, // Answer flush requests late
    output logic afready_s, // Flush acknowledge
    output int syncSeen // Cycles with sync request high counted
);
    timeunit 1ns;
    timeprecision 1ns;
    int waitCnt;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            syncSeen <= 0;
            afready_s <= 1'b0;
            waitCnt <= 0;
        end else begin
            if (syncreq_s === 1'b1)
                syncSeen <= syncSeen + 1;
            // Acknowledge drops as soon as the request is withdrawn
            waitCnt <= (afvalid_s === 1'b1) ? waitCnt + 1 : 0;
            afready_s <= (afvalid_s === 1'b1) && (waitCnt >= (slow ? 4 : 0));
        end
    end
endmodule

// >>> dv/tss_trace_sink_regs_test.sv
// Self-checking bench for the trace sink sync and integration block
`include "tss_params.svh"
module tss_trace_sink_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    import tss_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    tss_axi_req_t req = '0;
    tss_axi_rsp_t rsp;
    logic capEn, stV, fdF, bfF, cdF, avF, arF, flIn, trIn, wake, atv, slow;
    logic [4:0] stB;
    logic [127:0] atd;
    logic [6:0] atid;
    logic [3:0] atb;
    logic fdo, bfo, cdo, srq, afv, atr, afr, integ;
    logic [31:0] rd;
    logic [1:0] resp;
    int syncSeen;
    int nMismatch = 0;
    int checksDone = 0;

    always #50 ref_clk = ~ref_clk;

    tss_trace_sink_regs dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .axiReq(req), .axiRsp(rsp), .captureEnable(capEn),
        .storeValid(stV), .storeBytes(stB), .flushDoneFunc(fdF),
        .bufferFullFunc(bfF), .captureDoneFunc(cdF), .afvalidFunc(avF),
        .atreadyFunc(arF), .flush_request_in(flIn),
        .trigger_pulse_in(trIn), .atdata_s(atd), .atid_s(atid),
        .atbytes_s(atb), .atwakeup_s(wake), .afready_s(afr),
        .atvalid_s(atv), .flush_done_out(fdo), .buffer_full_out(bfo),
        .capture_done_out(cdo), .syncreq_s(srq), .afvalid_s(afv),
        .atready_s(atr), .integrationMode(integ));

    tss_trace_src src (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .syncreq_s(srq), .afvalid_s(afv), .slow(slow), .afready_s(afr),
        .syncSeen(syncSeen));

    ////////////////////////////////////////////////////////////////////////
    task automatic results;
        if (nMismatch == 0 && checksDone > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checksDone++;
        if (g !== e) begin
            nMismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Ready is looked at mid-cycle, where it equals what the edge samples
    task automatic axw(input logic [11:0] a, input logic [31:0] d);
        logic ta, tw, hb;
        int n;
        @(posedge ref_clk);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        hb = 1'b0;
        n = 0;
        while (!hb && n < 100) begin
            @(negedge ref_clk);
            ta = req.awvalid && rsp.awready === 1'b1;
            tw = req.wvalid && rsp.wready === 1'b1;
            hb = rsp.bvalid === 1'b1;
            resp = rsp.bresp;
            n++;
            @(posedge ref_clk);
            if (ta) req.awvalid <= 1'b0;
            if (tw) req.wvalid <= 1'b0;
            if (hb) req.bready <= 1'b0;
        end
        if (!hb) nMismatch++;
    endtask

    task automatic axr(input logic [11:0] a);
        logic ta, hr;
        int n;
        @(posedge ref_clk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        hr = 1'b0;
        n = 0;
        while (!hr && n < 100) begin
            @(negedge ref_clk);
            ta = req.arvalid && rsp.arready === 1'b1;
            hr = rsp.rvalid === 1'b1;
            rd = rsp.rdata;
            resp = rsp.rresp;
            n++;
            @(posedge ref_clk);
            if (ta) req.arvalid <= 1'b0;
            if (hr) req.rready <= 1'b0;
        end
        if (!hr) nMismatch++;
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        axr(a);
        chk(rd, e);
    endtask

    task automatic store(input int n);
        repeat (n) begin
            stV <= 1'b1;
            stB <= 5'h10;
            @(posedge ref_clk);
        end
        stV <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic pulse(input logic fl);
        if (fl) flIn <= 1'b1;
        else trIn <= 1'b1;
        repeat (2) @(posedge ref_clk);
        flIn <= 1'b0;
        trIn <= 1'b0;
        @(posedge ref_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rchk(`TSS_OFF_SYNC_RELOAD, 32'h0000000a);
        rchk(`TSS_OFF_INTEG_MODE, 32'h00000000);
        axr(12'h100);
        chk(32'(resp), 32'(`TSS_RESP_SLVERR));
        chk(rd, 32'h00000000);
        axw(12'h104, 32'h00000001);
        chk(32'(resp), 32'(`TSS_RESP_SLVERR));
    endtask

    task automatic t_func;
        logic [11:0] offs [6] = '{`TSS_OFF_EVT_OUT, `TSS_OFF_TRIG_FLUSH,
            `TSS_OFF_DATA_SAMPLE, `TSS_OFF_TRACE_OUT, `TSS_OFF_ID_SAMPLE,
            `TSS_OFF_CTRL_SAMPLE};
        axw(`TSS_OFF_EVT_OUT, 32'h00000002);
        axw(`TSS_OFF_TRACE_OUT, 32'h00000006);
        pulse(1'b1);
        for (int i = 0; i < 6; i++)
            rchk(offs[i], 32'h00000000);
        chk(32'({fdo, bfo, cdo, srq, afv, atr}), 32'h29);
    endtask

    task automatic t_sync;
        int b;
        axw(`TSS_OFF_SYNC_RELOAD, 32'h00000007);
        b = syncSeen;
        store(63);
        chk(32'(syncSeen), 32'(b));
        store(1);
        chk(32'(syncSeen), 32'(b + 1));
        store(7);
        chk(32'(syncSeen), 32'(b + 1));
        store(1);
        chk(32'(syncSeen), 32'(b + 2));
        capEn <= 1'b0;
        store(8);
        chk(32'(syncSeen), 32'(b + 2));
        capEn <= 1'b1;
        axw(`TSS_OFF_SYNC_RELOAD, 32'h00000000);
        store(8);
        chk(32'(syncSeen), 32'(b + 3));
        store(16);
        chk(32'(syncSeen), 32'(b + 3));
    endtask

    task automatic t_reload;
        logic [4:0] vals [8] = '{5'h00, 5'h01, 5'h06, 5'h07, 5'h1b,
            5'h1c, 5'h1f, 5'h0a};
        logic [4:0] x;
        for (int i = 0; i < 8; i++) begin
            x = ((vals[i] >= 5'h01 && vals[i] <= 5'h06) || vals[i] >= 5'h1c)
                ? 5'h1b : vals[i];
            axw(`TSS_OFF_SYNC_RELOAD, {27'h7ffffff, vals[i]});
            rchk(`TSS_OFF_SYNC_RELOAD, {27'h0, x});
        end
    endtask

    task automatic t_integ;
        logic [31:0] e;
        axw(`TSS_OFF_INTEG_MODE, 32'h00000001);
        rchk(`TSS_OFF_INTEG_MODE, 32'h00000001);
        chk(32'(integ), 32'h1);
        rchk(`TSS_OFF_TRIG_FLUSH, 32'h00000000);
        axw(`TSS_OFF_EVT_OUT, 32'h00000002);
        chk(32'({fdo, bfo, cdo}), 32'h2);
        rchk(`TSS_OFF_EVT_OUT, 32'h00000000);
        slow <= 1'b1;
        axw(`TSS_OFF_TRACE_OUT, 32'h00000006);
        chk(32'({srq, afv, atr}), 32'h6);
        rchk(`TSS_OFF_TRACE_OUT, 32'h00000000);
        repeat (8) @(posedge ref_clk);
        rchk(`TSS_OFF_CTRL_SAMPLE, {20'h0, atb, 5'h0, wake, 1'b1, atv});
        axw(`TSS_OFF_ID_SAMPLE, 32'h00000055);
        rchk(`TSS_OFF_ID_SAMPLE, {25'h0, atid});
        e = 32'(atd[0]);
        for (int i = 1; i < 17; i++)
            e[i] = atd[8 * i - 1];
        axw(`TSS_OFF_DATA_SAMPLE, 32'hffffffff);
        rchk(`TSS_OFF_DATA_SAMPLE, e);
        pulse(1'b1);
        rchk(`TSS_OFF_TRIG_FLUSH, 32'h00000002);
        rchk(`TSS_OFF_TRIG_FLUSH, 32'h00000000);
        pulse(1'b0);
        rchk(`TSS_OFF_TRIG_FLUSH, 32'h00000001);
        pulse(1'b0);
        axw(`TSS_OFF_INTEG_MODE, 32'h00000000);
        repeat (2) @(posedge ref_clk);
        chk(32'({integ, fdo, bfo, cdo, srq, afv, atr}), 32'h29);
        axw(`TSS_OFF_INTEG_MODE, 32'h00000001);
        rchk(`TSS_OFF_TRIG_FLUSH, 32'h00000000);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {capEn, stV, flIn, trIn, avF, bfF, slow} = '0;
        {fdF, cdF, arF, wake} = 4'hf;
        stB = 5'h00;
        atd = 128'h0123456789abcdeffedcba9876543210;
        atid = 7'h5a;
        atb = 4'h9;
        atv = 1'b0;
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        capEn <= 1'b1;
        t_reset();
        t_func();
        t_sync();
        t_reload();
        t_integ();
        results();
    end

    // Whole run needs well under a thousand cycles; allow five times more
    initial begin
        #(5000 * 100);
        nMismatch++;
        results();
    end
endmodule
